// ===== hw/backplane_if.sv
// Backplane trigger bus between this card and a peer card
`default_nettype none
interface backplane_if;
  logic [8:0] devOut;   // Device driven values
  logic [8:0] devOe;    // Device output enables
  logic [8:0] peerOut;  // Peer driven values
  logic [8:0] peerOe;   // Peer output enables
  logic [8:0] level;    // Resolved line levels

  // Lines 0..6 and star pulled low when idle; line 7 pulled up, wired AND
  always_comb begin
    level = (devOe & devOut) | (peerOe & peerOut);
    level[7] = ~((devOe[7] & ~devOut[7]) | (peerOe[7] & ~peerOut[7]));
  end

  modport device (output devOut, output devOe, input level);
  modport peer   (output peerOut, output peerOe, input level);
endinterface
`default_nettype wire

// ===== hw/trig_router_card.sv
// Card end: reference select, trigger output routing and readiness
// Operation
// - Reference setting zero internal, minus one backplane
// - Backplane reference feeds PLL, rate sets clock
// - Each setting changes only its own register
// - Every card listens, one card drives
// - Star line only with star card fitted; card drives it on route 9 unchecked
// - Routed trigger no longer triggers own card
// - Rising edge, low by acquisition stop
// - Route 0 none, 1..6 lines, 9 star
// - Never two cards on one line
// - Read-only bitmap of usable output lines
// - Line 7 reserved as shared readiness
// - Readiness open collector, low until ready
// - Detection only while readiness line high
// - No path from trigger inputs to outputs
// - All trigger line drivers off until route programmed; readiness pull-down follows pretrigger
`default_nettype none
module trig_router_card (
  input  wire logic        clock,           // 25 MHz clock
  input  wire logic        rst_n,           // Async reset, active low
  backplane_if.device      bp,              // Backplane trigger bus
  input  wire logic [15:0] regAddr,         // Register address
  input  wire logic [31:0] regWdata,        // Register write data
  input  wire logic        regWr,           // Write strobe
  input  wire logic        regRd,           // Read strobe
  output logic      [31:0] regRdata,        // Read data, next cycle
  input  wire logic        recognisedTrig,  // Internal trigger pulse
  input  wire logic        acqRunning,      // Acquisition running
  input  wire logic        pretrigDone,     // Pretrigger time elapsed
  output logic             selfTrig,        // Trigger for own card
  output logic             trigDetectEn,    // Trigger detection enabled
  output logic             pllUseBackplane, // PLL takes backplane ref
  output logic      [31:0] pllRate          // Sampling rate to PLL
);

  // Line one-hot for a route code, zero when none or invalid
  function automatic logic [8:0] routeToLines(input logic [3:0] code);
    logic [8:0] lines;
    lines = 9'h000;
    if (code >= trig_router_pkg::ROUTE_LINE_ZERO &&
        code <= trig_router_pkg::ROUTE_LINE_FIVE)
      lines[code - trig_router_pkg::ROUTE_LINE_ZERO] = 1'b1;
    else if (code == trig_router_pkg::ROUTE_STAR_LINE)
      lines[trig_router_pkg::STAR_BIT] = 1'b1;
    return lines;
  endfunction

  // Route codes that software may store: none, six lines, star
  function automatic logic routeLegal(input logic [31:0] value);
    logic isLine;
    logic isStar;
    isLine = value <= {28'h0000000, trig_router_pkg::ROUTE_LINE_FIVE};
    isStar = value == {28'h0000000, trig_router_pkg::ROUTE_STAR_LINE};
    return isLine || isStar;
  endfunction

  // Write strobe aimed at one register offset
  function automatic logic wrHit(input logic        wr,
                                 input logic [15:0] addr,
                                 input logic [15:0] ofs);
    return wr && addr == ofs;
  endfunction

  logic        refBackplane_ff;
  logic [3:0]  route_ff;
  logic [31:0] rate_ff;
  logic [31:0] rdata_ff;
  logic        ready1_ff;
  logic        ready2_ff;
  logic        held_ff;
  logic        selfTrig_ff;
  logic [8:0]  lineOe_ff;
  logic [8:0]  lineOut_ff;
  logic [8:0]  routeLines;
  logic        routeActive;
  logic        wrRef;
  logic        wrRoute;
  logic        wrRate;
  logic [31:0] statusWord;

  assign routeLines  = routeToLines(route_ff);
  assign routeActive = |routeLines;

  // Separate decodes keep each setting isolated from the others
  assign wrRef   = wrHit(regWr, regAddr, trig_router_pkg::OFS_REF_SOURCE);
  assign wrRoute = wrHit(regWr, regAddr, trig_router_pkg::OFS_OUT_ROUTE);
  assign wrRate  = wrHit(regWr, regAddr, trig_router_pkg::OFS_SAMPLE_RATE);

  // Reference source; codes other than 0 and -1 are ignored
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      refBackplane_ff <= 1'b0;
    else if (wrRef && regWdata == trig_router_pkg::REF_BACKPLANE)
      refBackplane_ff <= 1'b1;
    else if (wrRef && regWdata == trig_router_pkg::REF_INTERNAL)
      refBackplane_ff <= 1'b0;
  end

  // Output route; illegal codes leave the old route standing
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      route_ff <= trig_router_pkg::RST_ROUTE;
    else if (wrRoute && routeLegal(regWdata))
      route_ff <= regWdata[3:0];
  end

  // Sampling rate, handed to the PLL as written
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      rate_ff <= trig_router_pkg::RST_RATE;
    else if (wrRate)
      rate_ff <= regWdata;
  end

  // Status word; unused bits read as zero rather than stale data
  always_comb begin
    statusWord = 32'h00000000;
    statusWord[trig_router_pkg::ST_READY]     = ready2_ff;
    statusWord[trig_router_pkg::ST_LINE_HIGH] = held_ff;
    statusWord[trig_router_pkg::ST_PRETRIG]   = pretrigDone;
  end

  // Read mux, data stands one cycle after the strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h00000000;
    end else if (regRd) begin
      case (regAddr)
        trig_router_pkg::OFS_REF_SOURCE:
          rdata_ff <= {32{refBackplane_ff}};
        trig_router_pkg::OFS_OUT_ROUTE:
          rdata_ff <= {28'h0000000, route_ff};
        trig_router_pkg::OFS_OUT_USABLE:
          rdata_ff <= {16'h0000, trig_router_pkg::USABLE_MAP};
        trig_router_pkg::OFS_SAMPLE_RATE:
          rdata_ff <= rate_ff;
        trig_router_pkg::OFS_STATUS:
          rdata_ff <= statusWord;
        default:
          rdata_ff <= 32'h00000000;
      endcase
    end else begin
      rdata_ff <= 32'h00000000;
    end
  end

  // Readiness line from the bus; stage one feeds stage two only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ready1_ff <= 1'b0;
      ready2_ff <= 1'b0;
    end else begin
      ready1_ff <= bp.level[trig_router_pkg::READY_BIT];
      ready2_ff <= ready1_ff;
    end
  end

  // Detection enable follows the wired AND of all cards
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      trigDetectEn <= 1'b0;
    else
      trigDetectEn <= ready2_ff;
  end

  // Routed trigger level: set by own trigger, cleared when the board stops.
  // Only the internal trigger feeds it, never a bus line.
  // A route write drops it, so a new line never rises without a trigger.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      held_ff <= 1'b0;
    else if (!acqRunning || !routeActive)
      held_ff <= 1'b0;
    else if (wrRoute)
      held_ff <= 1'b0;
    else if (recognisedTrig && ready2_ff)
      held_ff <= 1'b1;
  end

  // Own card triggers itself only while no route is set
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      selfTrig_ff <= 1'b0;
    else
      selfTrig_ff <= recognisedTrig && ready2_ff && !routeActive;
  end

  // Line drivers: off after reset, one line while routed
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lineOe_ff  <= 9'h000;
      lineOut_ff <= 9'h000;
    end else begin
      lineOe_ff  <= routeLines;
      lineOut_ff <= routeLines & {9{held_ff}};
      // Line 7: pull low until pretrigger done, then release
      lineOe_ff[trig_router_pkg::READY_BIT]  <= ~pretrigDone;
      lineOut_ff[trig_router_pkg::READY_BIT] <= 1'b0;
    end
  end

  assign bp.devOe   = lineOe_ff;
  assign bp.devOut  = lineOut_ff;
  assign regRdata   = rdata_ff;
  assign selfTrig   = selfTrig_ff;
  assign pllUseBackplane = refBackplane_ff;
  assign pllRate    = rate_ff;
endmodule
`default_nettype wire

// ===== hw/trig_router_peer.sv
// Peer card end: drives one line, listens on selected lines
`default_nettype none
module trig_router_peer (
  input  wire logic   clock,            // 25 MHz clock
  input  wire logic   rst_n,            // Async reset, active low
  backplane_if.peer   bp,               // Backplane trigger bus
  input  wire logic   driveEnable,      // Drive own trigger out
  input  wire logic [3:0] driveLine,    // 0..5 line, 8 star
  input  wire logic   starCardPresent,  // Star trigger card fitted
  input  wire logic [8:0] inputMask,    // Lines used as trigger source
  input  wire logic   localTrig,        // Own recognised trigger pulse
  input  wire logic   acqRunning,       // Acquisition running
  input  wire logic   pretrigDone,      // Own pretrigger elapsed
  output logic        trigFired,        // Trigger seen on a source line
  output logic        detectEnable,     // Shared readiness high
  output logic        cfgError          // Illegal setup requested
);
  logic [8:0] sync1_ff, sync2_ff, sync3_ff;
  logic [8:0] outOe_ff, outVal_ff;
  logic       held_ff, fired_ff, cfgErr_ff;
  logic [8:0] lineSel;
  logic       badCfg;

  // One line at most, star only with a star card
  always_comb begin
    lineSel = 9'h000;
    badCfg  = (inputMask == 9'h000);
    if (driveEnable) begin
      if (driveLine <= 4'h5)
        lineSel[driveLine] = 1'b1;
      else if (driveLine == 4'h8 && starCardPresent)
        lineSel[trig_router_pkg::STAR_BIT] = 1'b1;
      else
        badCfg = 1'b1;
    end
  end

  // Two-stage sync of every bus line, third stage for edges
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= 9'h000;
      sync2_ff <= 9'h000;
      sync3_ff <= 9'h000;
    end else begin
      sync1_ff <= bp.level;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // Held high from trigger until acquisition stops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      held_ff <= 1'b0;
    else if (!acqRunning)
      held_ff <= 1'b0;
    else if (localTrig && sync2_ff[trig_router_pkg::READY_BIT])
      held_ff <= 1'b1;
  end

  // Drivers and readiness pull-down, open collector
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      outOe_ff  <= 9'h000;
      outVal_ff <= 9'h000;
    end else begin
      outOe_ff  <= lineSel;
      outVal_ff <= lineSel & {9{held_ff}};
      outOe_ff[trig_router_pkg::READY_BIT]  <= ~pretrigDone;
      outVal_ff[trig_router_pkg::READY_BIT] <= 1'b0;
    end
  end

  // Rising edge on any selected source while ready
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fired_ff  <= 1'b0;
      cfgErr_ff <= 1'b0;
    end else begin
      fired_ff  <= sync2_ff[trig_router_pkg::READY_BIT] &&
                   |(inputMask & sync2_ff & ~sync3_ff);
      cfgErr_ff <= badCfg;
    end
  end

  assign bp.peerOe  = outOe_ff;
  assign bp.peerOut = outVal_ff;
  assign trigFired    = fired_ff;
  assign detectEnable = sync2_ff[trig_router_pkg::READY_BIT];
  assign cfgError     = cfgErr_ff;
endmodule
`default_nettype wire

// ===== hw/trig_router_pkg.sv
// Constants shared by both backplane trigger ends
`default_nettype none
package trig_router_pkg;
  localparam int          CLOCK_HZ        = 25_000_000;
  localparam int          LINE_COUNT      = 9;  // Lines 0..7 plus star
  localparam int          STAR_BIT        = 8;
  localparam int          READY_BIT       = 7;
  // Register offsets as printed, plus two of our own
  localparam logic [15:0] OFS_REF_SOURCE  = 16'h4EAC;
  localparam logic [15:0] OFS_OUT_ROUTE   = 16'h9D6C;
  localparam logic [15:0] OFS_OUT_USABLE  = 16'h9D6D;
  localparam logic [15:0] OFS_SAMPLE_RATE = 16'h1000;
  localparam logic [15:0] OFS_STATUS      = 16'h1004;
  // Reference source codes
  localparam logic [31:0] REF_INTERNAL    = 32'h00000000;
  localparam logic [31:0] REF_BACKPLANE   = 32'hFFFFFFFF;  // Minus one
  // Output route codes
  localparam logic [3:0]  ROUTE_NONE      = 4'h0;
  localparam logic [3:0]  ROUTE_LINE_ZERO = 4'h1;
  localparam logic [3:0]  ROUTE_LINE_FIVE = 4'h6;
  localparam logic [3:0]  ROUTE_STAR_LINE = 4'h9;
  // Usable output lines: 0..5 and star
  localparam logic [15:0] USABLE_MAP      = 16'h013F;
  // Reset values
  localparam logic [3:0]  RST_ROUTE       = 4'h0;
  localparam logic [31:0] RST_RATE        = 32'h00000000;
  // Status bit positions
  localparam int          ST_READY        = 0;
  localparam int          ST_LINE_HIGH    = 1;
  localparam int          ST_PRETRIG      = 2;
endpackage
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for card and peer ends joined on one bus
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) \
  begin fails++; \
  $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rst_n, regWr, regRd, recTrig, acqRun, preCard;
  logic        selfTrig, detEn, pllBp, drvEn, starOk, locTrig, preP;
  logic        trigFired, detP, cfgErr;
  logic [15:0] regAddr;
  logic [31:0] regWdata, regRdata, pllRate, rdv, expRef, expRate;
  logic [31:0] lfsr = 32'hBC71D425;
  logic [3:0]  drvLine;
  logic [8:0]  inMask;
  int          fails = 0, samples_checked = 0, cyc = 0, expRoute;
  int          codes[7] = '{1, 2, 3, 4, 5, 6, 9};
  backplane_if bpIf();
  trig_router_card trig_router_card_inst (.clock(clock), .rst_n(rst_n),
    .bp(bpIf.device), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .recognisedTrig(recTrig),
    .acqRunning(acqRun), .pretrigDone(preCard), .selfTrig(selfTrig),
    .trigDetectEn(detEn), .pllUseBackplane(pllBp), .pllRate(pllRate));
  trig_router_peer trig_router_peer_inst (.clock(clock), .rst_n(rst_n),
    .bp(bpIf.peer), .driveEnable(drvEn), .driveLine(drvLine),
    .starCardPresent(starOk), .inputMask(inMask), .localTrig(locTrig),
    .acqRunning(acqRun), .pretrigDone(preP), .trigFired(trigFired),
    .detectEnable(detP), .cfgError(cfgErr));
  trig_router_monitor trig_router_monitor_inst (.clock(clock), .rst_n(rst_n),
    .devOut(bpIf.devOut), .devOe(bpIf.devOe), .peerOut(bpIf.peerOut),
    .peerOe(bpIf.peerOe), .level(bpIf.level));
  // Free-running bus clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Hang guard, far above the expected run
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Write through the plain port, model follows legal values only
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a; regWdata <= d; regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
    if (a == trig_router_pkg::OFS_REF_SOURCE && (d == 0 || d == '1))
      expRef = d;
    if (a == trig_router_pkg::OFS_OUT_ROUTE && (d <= 6 || d == 9))
      expRoute = d;
    if (a == trig_router_pkg::OFS_SAMPLE_RATE) expRate = d;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clock);
    regAddr <= a; regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1 rdv = regRdata;
  endtask
  task automatic chkRegs();
    rd(trig_router_pkg::OFS_OUT_ROUTE);
    `CHK("route", 32'(expRoute), rdv)
    rd(trig_router_pkg::OFS_REF_SOURCE);
    `CHK("refsrc", expRef, rdv)
    rd(trig_router_pkg::OFS_SAMPLE_RATE);
    `CHK("rate", expRate, rdv)
    rd(trig_router_pkg::OFS_OUT_USABLE);
    `CHK("usable", 32'h0000013F, rdv)
    rd(16'h2222);
    `CHK("unmapped", 32'h00000000, rdv)
  endtask
  // Internal trigger with random lead; b is the routed line or -1
  task automatic fire(input int b, input logic e, input logic s);
    lfsr = nextRand(lfsr);
    repeat (lfsr[1:0]) @(posedge clock);
    @(posedge clock); recTrig <= 1'b1;
    @(posedge clock); recTrig <= 1'b0;
    #1 `CHK("selfTrig", s, selfTrig)
    @(posedge clock); #1;
    if (b >= 0) `CHK("lineUp", e, bpIf.level[b])
    @(posedge clock); acqRun <= 1'b0;
    repeat (2) @(posedge clock); #1;
    if (b >= 0) `CHK("lineDown", 1'b0, bpIf.level[b])
    `CHK("fired", (b >= 0 && e) ? inMask[b] : 1'b0, trigFired)
    @(posedge clock); acqRun <= 1'b1;
  endtask
  initial begin
    {rst_n, regWr, regRd, recTrig, drvEn, locTrig} = '0;
    {acqRun, preCard, preP, starOk} = '1;
    regAddr = '0; regWdata = '0; drvLine = 4'h0; inMask = 9'h004;
    expRoute = 0; expRef = '0; expRate = '0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    chkRegs();
    `CHK("pllBp", 1'b0, pllBp)
    wr(trig_router_pkg::OFS_REF_SOURCE, 32'h00000005);
    wr(trig_router_pkg::OFS_REF_SOURCE, 32'hFFFFFFFF);
    lfsr = nextRand(lfsr);
    wr(trig_router_pkg::OFS_SAMPLE_RATE, lfsr);
    @(posedge clock); #1;
    `CHK("pllBp", 1'b1, pllBp)
    `CHK("pllRate", expRate, pllRate)
    chkRegs();
    wr(trig_router_pkg::OFS_REF_SOURCE, 32'h00000000);
    @(posedge clock); #1 `CHK("pllBp", 1'b0, pllBp)
    foreach (codes[i]) begin
      wr(trig_router_pkg::OFS_OUT_ROUTE, 32'(codes[i]));
      fire(codes[i] == 9 ? 8 : codes[i] - 1, 1'b1, 1'b0);
    end
    wr(trig_router_pkg::OFS_OUT_ROUTE, 32'h00000007);
    wr(trig_router_pkg::OFS_OUT_USABLE, 32'h00000000);
    chkRegs();
    wr(trig_router_pkg::OFS_OUT_ROUTE, 32'h00000000);
    fire(-1, 1'b0, 1'b1);
    preP <= 1'b0;
    repeat (8) @(posedge clock); #1;
    `CHK("ready", 1'b0, bpIf.level[7])
    `CHK("detEn", 1'b0, detEn)
    `CHK("detP", 1'b0, detP)
    rd(trig_router_pkg::OFS_STATUS);
    `CHK("status", 32'h1 << trig_router_pkg::ST_PRETRIG, rdv)
    wr(trig_router_pkg::OFS_OUT_ROUTE, 32'h00000002);
    fire(1, 1'b0, 1'b0);
    preP <= 1'b1;
    repeat (6) @(posedge clock); #1 `CHK("detEn", 1'b1, detEn)
    `CHK("detP", 1'b1, detP)
    wr(trig_router_pkg::OFS_OUT_ROUTE, 32'h00000003);
    drvEn <= 1'b1; locTrig <= 1'b1;
    repeat (4) @(posedge clock); #1;
    `CHK("noEcho", 1'b0, bpIf.level[2] | bpIf.devOe[0])
    `CHK("cfgOk", 1'b0, cfgErr)
    // Star route without a star card is refused by the peer
    @(posedge clock);
    drvLine <= 4'h8;
    starOk  <= 1'b0;
    repeat (2) @(posedge clock); #1;
    `CHK("cfgErr", 1'b1, cfgErr)
    // Second reset in mid-run: settings fall back, drivers off
    @(posedge clock);
    drvEn   <= 1'b0;
    locTrig <= 1'b0;
    rst_n   <= 1'b0;
    expRoute = 0;
    expRef   = '0;
    expRate  = '0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    chkRegs();
    `CHK("pllBp", 1'b0, pllBp)
    `CHK("drvOff", 9'h000, bpIf.devOe)
    finish_test();
  end
endmodule
`default_nettype wire

// ===== sim/trig_router_monitor.sv
// Checker of the backplane trigger bus between card and peer
`default_nettype none
module trig_router_monitor (
  input wire logic       clock,    // Bus clock
  input wire logic       rst_n,    // Async reset, active low
  input wire logic [8:0] devOut,   // Card values
  input wire logic [8:0] devOe,    // Card enables
  input wire logic [8:0] peerOut,  // Peer values
  input wire logic [8:0] peerOe,   // Peer enables
  input wire logic [8:0] level     // Resolved levels
);
  // Trigger lines 0..6 and star, readiness line left out
  localparam logic [8:0] TRIG = 9'h17F;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Readiness may only ever be pulled low
  property p_dev_oc; devOe[7] |-> !devOut[7]; endproperty
  a_dev_oc: assert property (p_dev_oc)
    else $error("card drives readiness high");
  property p_peer_oc; peerOe[7] |-> !peerOut[7]; endproperty
  a_peer_oc: assert property (p_peer_oc)
    else $error("peer drives readiness high");
  property p_one_route; $onehot0(devOe & TRIG); endproperty
  a_one_route: assert property (p_one_route)
    else $error("card drives several trigger lines");
  property p_usable; !devOe[6] && !peerOe[6]; endproperty
  a_usable: assert property (p_usable)
    else $error("line six driven");
  property p_reset_off; $rose(rst_n) |-> (devOe & TRIG) == 9'h000; endproperty
  a_reset_off: assert property (p_reset_off)
    else $error("trigger driver on after reset");
  // Enable first, edge afterwards, so the line shows a clean rise
  property p_rise;
    $rose(|(devOut & devOe & TRIG)) |-> $past(|(devOe & TRIG));
  endproperty
  a_rise: assert property (p_rise)
    else $error("trigger rise without standing driver");
  property p_contend; (devOe & peerOe & TRIG) == 9'h000; endproperty
  a_contend: assert property (p_contend)
    else $error("two cards on one line");
  // Margin covers the synchroniser depth plus trigger latency
  property p_gate;
    !level[7] [*7] |-> !$rose(|(devOut & devOe & TRIG));
  endproperty
  a_gate: assert property (p_gate)
    else $error("trigger driven while not ready");
endmodule
`default_nettype wire
